// file: rtl/era_pkg.sv
package era_pkg;
	localparam int PIN_COUNT = 11;
	localparam int PIN_W = 4;
	localparam int DATA_W = 32;
	localparam int DELAY_W = 4;
	localparam logic [PIN_W-1:0] MAX_PIN = 4'hA;
	// built-in settling time before each rotation-mode sample, and the extra step per delay code
	localparam int SETTLE_NS = 64;
	localparam int STEP_NS = 32;
	localparam int CLK_NS = 4;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 16;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETTLE = 2'b01,
		ST_CONV = 2'b10
	} era_state_t;
endpackage : era_pkg

// file: rtl/era_core.sv
`timescale 1ns/1ps
module era_core (
	input wire logic ref_clk_in,
	input wire logic nrst_in,
	input wire logic rotate_en_in,
	input wire logic [3:0] settle_delay_in,
	input wire logic [3:0] src_a_pin_in,
	input wire logic [3:0] src_b_pin_in,
	input wire logic conv_start_in,
	input wire logic conv_done_in,
	input wire logic [31:0] conv_data_in,
	output logic [3:0] excitation_source_a_pin_out,
	output logic [3:0] excitation_source_b_pin_out,
	output logic pins_valid_out,
	output logic sample_go_out,
	output logic result_valid_out,
	output logic [31:0] result_out,
	output logic busy_out
);
	era_pkg::era_state_t state_reg, state_next;
	logic swapped_reg;
	logic have_prev_reg;
	logic rot_active_reg;
	logic [31:0] prev_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [3:0] a_pin_reg, b_pin_reg;
	logic pins_valid_reg, go_reg, rv_reg, busy_reg;
	logic [31:0] res_reg;

	wire start_w = (state_reg == era_pkg::ST_IDLE) && conv_start_in;
	wire settle_done_w = (state_reg == era_pkg::ST_SETTLE) && (cnt_reg == 16'h0000);
	wire done_w = (state_reg == era_pkg::ST_CONV) && conv_done_in;
	wire pin_ok_w = (src_a_pin_in <= era_pkg::MAX_PIN) && (src_b_pin_in <= era_pkg::MAX_PIN);
	// swap on even conversions only while rotation runs
	wire use_swap_w = rotate_en_in && rot_active_reg && !swapped_reg;
	wire [3:0] a_sel_w = use_swap_w ? src_b_pin_in : src_a_pin_in;
	wire [3:0] b_sel_w = use_swap_w ? src_a_pin_in : src_b_pin_in;
	wire [32:0] sum_w = {1'b0, conv_data_in} + {1'b0, prev_reg};
	wire [31:0] avg_w = sum_w[32:1];
	// wait = built-in interval plus programmed extension, in rotation mode only
	wire [15:0] wait_w = 16'(era_pkg::SETTLE_CYC)
		+ 16'(era_pkg::STEP_CYC) * {12'h000, settle_delay_in};

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			era_pkg::ST_IDLE: begin
				if (start_w) begin
					state_next = rotate_en_in ? era_pkg::ST_SETTLE : era_pkg::ST_CONV;
					cnt_next = wait_w - 16'h0001;
				end
			end
			era_pkg::ST_SETTLE: begin
				if (cnt_reg == 16'h0000) begin
					state_next = era_pkg::ST_CONV;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			era_pkg::ST_CONV: begin
				if (conv_done_in) begin
					state_next = era_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = era_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= era_pkg::ST_IDLE;
			cnt_reg <= 16'h0000;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			a_pin_reg <= 4'h0;
			b_pin_reg <= 4'h0;
			pins_valid_reg <= 1'b0;
		end else if (start_w) begin
			a_pin_reg <= a_sel_w;
			b_pin_reg <= b_sel_w;
			pins_valid_reg <= pin_ok_w;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rot_active_reg <= 1'b0;
			swapped_reg <= 1'b0;
			have_prev_reg <= 1'b0;
			prev_reg <= 32'h0000_0000;
		end else if (!rotate_en_in) begin
			rot_active_reg <= 1'b0;
			swapped_reg <= 1'b0;
			have_prev_reg <= 1'b0;
		end else if (start_w) begin
			rot_active_reg <= 1'b1;
			swapped_reg <= use_swap_w;
		end else if (done_w) begin
			have_prev_reg <= 1'b1;
			prev_reg <= conv_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			go_reg <= 1'b0;
			rv_reg <= 1'b0;
			res_reg <= 32'h0000_0000;
			busy_reg <= 1'b0;
		end else begin
			go_reg <= (settle_done_w || (start_w && !rotate_en_in));
			busy_reg <= (state_next != era_pkg::ST_IDLE);
			rv_reg <= done_w && (!rotate_en_in || have_prev_reg);
			if (done_w) begin
				res_reg <= (rotate_en_in && have_prev_reg) ? avg_w : conv_data_in;
			end
		end
	end

	assign excitation_source_a_pin_out = a_pin_reg;
	assign excitation_source_b_pin_out = b_pin_reg;
	assign pins_valid_out = pins_valid_reg;
	assign sample_go_out = go_reg;
	assign result_valid_out = rv_reg;
	assign result_out = res_reg;
	assign busy_out = busy_reg;

	// checks on what the design drives
	first_held_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(done_w && rotate_en_in && !have_prev_reg) |=> !result_valid_out)
		else $error("first rotated result not withheld");
	avg_value_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(done_w && rotate_en_in && have_prev_reg) |=> (result_out == $past(avg_w)))
		else $error("average wrong");
	direct_out_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(done_w && !rotate_en_in) |=> (result_valid_out && result_out == $past(conv_data_in)))
		else $error("direct result wrong");
	swap_alt_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && rotate_en_in && rot_active_reg) |=> (swapped_reg != $past(swapped_reg)))
		else $error("swap did not alternate");
	normal_pins_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && !rotate_en_in) |=> (excitation_source_a_pin_out == $past(src_a_pin_in)))
		else $error("source moved while not rotating");
	settle_wait_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && rotate_en_in) |=> !sample_go_out [*2])
		else $error("sample before settling");
	settle_len_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && rotate_en_in && settle_delay_in == 4'h0) |-> ##17 sample_go_out)
		else $error("settle length wrong");
	pin_range_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		pins_valid_out |-> (excitation_source_a_pin_out <= era_pkg::MAX_PIN))
		else $error("pin out of range");

	// one-cycle pulses and busy framing
	go_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		sample_go_out |=> !sample_go_out)
		else $error("sample strobe longer than one cycle");
	rv_pulse_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		result_valid_out |=> !result_valid_out)
		else $error("result strobe longer than one cycle");
	busy_start_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		start_w |=> busy_out)
		else $error("busy not raised after start");

	// routing
	swap_pins_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && use_swap_w) |=> (excitation_source_a_pin_out == $past(src_b_pin_in)
		&& excitation_source_b_pin_out == $past(src_a_pin_in)))
		else $error("sources not exchanged");
	pin_range_b_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		pins_valid_out |-> (excitation_source_b_pin_out <= era_pkg::MAX_PIN))
		else $error("second pin out of range");

	// settling and sample timing
	direct_go_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && !rotate_en_in) |=> sample_go_out)
		else $error("direct sample not immediate");
	settle_min_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && rotate_en_in) |=> !sample_go_out [*8] ##1 !sample_go_out [*8])
		else $error("built-in settle cut short");
	settle_one_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && rotate_en_in && settle_delay_in == 4'h1) |-> ##25 sample_go_out)
		else $error("settle length wrong for code one");
	settle_max_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(start_w && rotate_en_in && settle_delay_in == 4'hF) |-> ##137 sample_go_out)
		else $error("settle length wrong for top code");

	// averaged results keep coming
	avg_valid_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		(done_w && rotate_en_in && have_prev_reg) |=> result_valid_out)
		else $error("averaged result not published");

	// scenarios reached
	rot_avg_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		done_w && rotate_en_in && have_prev_reg);
	direct_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		done_w && !rotate_en_in);
	long_delay_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		start_w && rotate_en_in && settle_delay_in == 4'hF);
	swap_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		start_w && use_swap_w);
	withheld_c: cover property (@(posedge ref_clk_in) disable iff (!nrst_in)
		done_w && rotate_en_in && !have_prev_reg);
endmodule : era_core

// file: testbench/tb_excitation_rotation_averager.sv
`timescale 1ns/1ps
module tb_excitation_rotation_averager;
	logic clk = 1'b0, nrst = 1'b0, rot = 1'b0, st = 1'b0, dn = 1'b0;
	logic [3:0] dly = 4'h0, pa = 4'h3, pb = 4'h7, oa, ob;
	logic [31:0] din = 32'h0000_0000, res;
	logic pv, go, rv, busy;
	int err_count = 0, checks_done = 0, cyc = 0;
	always #2 clk = ~clk;
	era_core uut (.ref_clk_in(clk), .nrst_in(nrst), .rotate_en_in(rot), .settle_delay_in(dly),
		.src_a_pin_in(pa), .src_b_pin_in(pb), .conv_start_in(st), .conv_done_in(dn),
		.conv_data_in(din), .excitation_source_a_pin_out(oa), .excitation_source_b_pin_out(ob),
		.pins_valid_out(pv), .sample_go_out(go), .result_valid_out(rv), .result_out(res),
		.busy_out(busy));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic conv(input logic [31:0] d, input int wc, input logic [3:0] ea,
		input logic [3:0] eb, input logic pub, input logic [31:0] er);
		int n;
		n = 1;
		st = 1'b1;
		@(negedge clk);
		st = 1'b0;
		while (go !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("go_delay", wc, n);
		chk("busy_run", 1, busy);
		chk("pin_a", ea, oa);
		chk("pin_b", eb, ob);
		dn = 1'b1;
		din = d;
		@(negedge clk);
		dn = 1'b0;
		chk("res_valid", pub, rv);
		if (pub) chk("result", er, res);
		chk("busy_end", 0, busy);
	endtask : conv
	task automatic t_direct;
		rot = 1'b0;
		conv(32'h1234_5678, 1, 4'h3, 4'h7, 1'b1, 32'h1234_5678);
		conv(32'hFFFF_0001, 1, 4'h3, 4'h7, 1'b1, 32'hFFFF_0001);
		chk("pins_valid", 1, pv);
	endtask : t_direct
	task automatic t_rotate;
		rot = 1'b1;
		conv(32'hFFFF_FFFF, 17, 4'h3, 4'h7, 1'b0, 32'h0000_0000);
		conv(32'hFFFF_FFFD, 17, 4'h7, 4'h3, 1'b1, 32'hFFFF_FFFE);
		conv(32'h0000_0003, 17, 4'h3, 4'h7, 1'b1, 32'h8000_0000);
		conv(32'h0000_0007, 17, 4'h7, 4'h3, 1'b1, 32'h0000_0005);
	endtask : t_rotate
	task automatic t_delay;
		rot = 1'b0;
		@(negedge clk);
		rot = 1'b1;
		dly = 4'hF;
		conv(32'h0000_0010, 137, 4'h3, 4'h7, 1'b0, 32'h0000_0000);
		dly = 4'h1;
		conv(32'h0000_0020, 25, 4'h7, 4'h3, 1'b1, 32'h0000_0018);
	endtask : t_delay
	task automatic t_badpin;
		rot = 1'b0;
		dly = 4'h0;
		pa = 4'hB;
		pb = 4'hA;
		conv(32'h0000_0001, 1, 4'hB, 4'hA, 1'b1, 32'h0000_0001);
		chk("pins_bad", 0, pv);
		pa = 4'h0;
		conv(32'h0000_0002, 1, 4'h0, 4'hA, 1'b1, 32'h0000_0002);
		chk("pins_edge", 1, pv);
	endtask : t_badpin
	task automatic t_reset;
		dly = 4'h0;
		nrst = 1'b0;
		@(negedge clk);
		chk("busy_rst2", 0, busy);
		chk("rv_rst2", 0, rv);
		chk("res_rst2", 0, res);
		chk("pv_rst2", 0, pv);
		chk("pin_rst2", 0, oa);
		@(negedge clk);
		nrst = 1'b1;
		conv(32'h0000_0040, 17, 4'h3, 4'h7, 1'b0, 32'h0000_0000);
		conv(32'h0000_0060, 17, 4'h7, 4'h3, 1'b1, 32'h0000_0050);
	endtask : t_reset
	task automatic t_manual;
		logic [31:0] r1;
		rot = 1'b0;
		pa = 4'h3;
		pb = 4'h7;
		conv(32'h0000_0100, 1, 4'h3, 4'h7, 1'b1, 32'h0000_0100);
		r1 = res;
		pa = 4'h7;
		pb = 4'h3;
		conv(32'h0000_0301, 1, 4'h7, 4'h3, 1'b1, 32'h0000_0301);
		chk("manual_avg", 32'h0000_0200, 32'((33'(r1) + 33'(res)) >> 1));
	endtask : t_manual
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		chk("busy_reset", 0, busy);
		chk("rv_reset", 0, rv);
		t_direct();
		t_rotate();
		t_delay();
		t_reset();
		t_badpin();
		t_manual();
		tally_and_finish();
	end
endmodule : tb_excitation_rotation_averager
